// *** pcr_clock_ratio.sv ***
// strap capture, ratio decode and platform/memory clock enables
`timescale 1ns/1ns
`include "pcr_params.svh"
module pcr_clock_ratio #(
   parameter int SETTLE_CYC = `PCR_SETTLE_CYC
) (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // board strap pins
   input  wire logic [`PCR_STRAP_W-1:0]   clock_ratio_strap,
   // decoded configuration
   output logic [`PCR_STRAP_W-1:0]        strap_code_ff,
   output logic [`PCR_RATIO_W-1:0]        ratio_ff,
   output logic                           config_valid_ff,
   output logic                           config_invalid_ff,
   // derived clock enables, once a legal code is locked: platform high every cycle, memory every second cycle
   output logic                           platform_bus_clock_ff,
   output logic                           memory_bus_clock_ff
);
   // the settle counter is only SETTLE_W bits wide, and two cycles are the least that rejects a glitch
   if (SETTLE_CYC < `PCR_SETTLE_MIN || SETTLE_CYC > `PCR_SETTLE_MAX) begin : g_bad_settle
      $error("SETTLE_CYC out of range");
   end

   // last settle count, cut on purpose to the counter width
   localparam logic [`PCR_SETTLE_W-1:0] SETTLE_LAST = SETTLE_CYC[`PCR_SETTLE_W-1:0];

   // strap code to multiplier; reserved codes give no ratio at all
   function automatic logic [`PCR_RATIO_W-1:0] pcr_decode(input logic [`PCR_STRAP_W-1:0] code);
      case (code)
         `PCR_CODE_R16: pcr_decode = `PCR_VAL_R16;
         `PCR_CODE_R2:  pcr_decode = `PCR_VAL_R2;
         `PCR_CODE_R3:  pcr_decode = `PCR_VAL_R3;
         `PCR_CODE_R4:  pcr_decode = `PCR_VAL_R4;
         `PCR_CODE_R5:  pcr_decode = `PCR_VAL_R5;
         `PCR_CODE_R6:  pcr_decode = `PCR_VAL_R6;
         `PCR_CODE_R8:  pcr_decode = `PCR_VAL_R8;
         `PCR_CODE_R9:  pcr_decode = `PCR_VAL_R9;
         `PCR_CODE_R10: pcr_decode = `PCR_VAL_R10;
         `PCR_CODE_R12: pcr_decode = `PCR_VAL_R12;
         `PCR_CODE_R20: pcr_decode = `PCR_VAL_R20;
         default:       pcr_decode = `PCR_RATIO_NONE;
      endcase
   endfunction : pcr_decode

   // reserved codes are told apart by their missing ratio
   function automatic logic pcr_is_reserved(input logic [`PCR_STRAP_W-1:0] code);
      pcr_is_reserved = (pcr_decode(code) == `PCR_RATIO_NONE);
   endfunction : pcr_is_reserved

   // settle counter step, used by both counting states
   function automatic logic [`PCR_SETTLE_W-1:0] pcr_count_up(input logic [`PCR_SETTLE_W-1:0] cnt);
      pcr_count_up = cnt + `PCR_SETTLE_ONE;
   endfunction : pcr_count_up

   logic [`PCR_STRAP_W-1:0]  sync1_ff;
   logic [`PCR_STRAP_W-1:0]  sync2_ff;
   logic [`PCR_SETTLE_W-1:0] settle_ff;
   pcr_pkg::pcr_state_t      state_ff;
   logic                     half_ff;
   logic                     strap_quiet;
   logic                     lock_now;
   logic                     code_reserved;
   logic [`PCR_RATIO_W-1:0]  dec;

   // strap pins are asynchronous to sys_clk; only the second flop is read
   always_ff @(posedge sys_clk) begin
      sync1_ff <= clock_ratio_strap;
   end

   always_ff @(posedge sys_clk) begin
      sync2_ff <= sync1_ff;
   end

   // strap unchanged since the last capture
   assign strap_quiet = (sync2_ff == strap_code_ff);

   // fill the synchroniser, wait for a quiet strap, then lock until the next reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff <= pcr_pkg::PCR_SYNC;
      end else begin
         case (state_ff)
            pcr_pkg::PCR_SYNC: begin
               if (settle_ff == `PCR_SYNC_LAST) begin
                  state_ff <= pcr_pkg::PCR_SETTLE;
               end
            end
            pcr_pkg::PCR_SETTLE: begin
               if (strap_quiet && settle_ff == SETTLE_LAST) begin // [R04]
                  state_ff <= pcr_pkg::PCR_LOCKED;
               end
            end
            pcr_pkg::PCR_LOCKED: begin
               state_ff <= pcr_pkg::PCR_LOCKED;
            end
            default: begin
               state_ff <= pcr_pkg::PCR_SYNC;
            end
         endcase
      end
   end

   // one counter serves both waits; cleared on the way into settling so the full window is seen
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         settle_ff <= `PCR_SETTLE_ZERO;
      end else begin
         case (state_ff)
            pcr_pkg::PCR_SYNC: begin
               if (settle_ff == `PCR_SYNC_LAST) begin
                  settle_ff <= `PCR_SETTLE_ZERO;
               end else begin
                  settle_ff <= pcr_count_up(settle_ff);
               end
            end
            pcr_pkg::PCR_SETTLE: begin
               if (!strap_quiet) begin // [R04]
                  settle_ff <= `PCR_SETTLE_ZERO;
               end else if (settle_ff != SETTLE_LAST) begin
                  settle_ff <= pcr_count_up(settle_ff);
               end
            end
            default: begin
               settle_ff <= settle_ff;
            end
         endcase
      end
   end

   // the strap is followed only while settling; after lock it is ignored
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         strap_code_ff <= `PCR_STRAP_RST;
      end else if (state_ff == pcr_pkg::PCR_SETTLE) begin
         strap_code_ff <= sync2_ff; // [R01]
      end
   end

   assign dec           = pcr_decode(strap_code_ff); // [R02]
   assign code_reserved = pcr_is_reserved(strap_code_ff); // [R07]

   // results are written once, in the first locked cycle
   assign lock_now = (state_ff == pcr_pkg::PCR_LOCKED) && !config_valid_ff && !config_invalid_ff;

   // ratio only from the sampled code, never a fallback [R03]
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ratio_ff <= `PCR_RATIO_NONE;
      end else if (lock_now) begin
         ratio_ff <= dec; // [R03]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         config_valid_ff <= 1'b0;
      end else if (lock_now) begin
         config_valid_ff <= !code_reserved; // [R03]
      end
   end

   // a reserved code is reported, not replaced by some multiplier
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         config_invalid_ff <= 1'b0;
      end else if (lock_now) begin
         config_invalid_ff <= code_reserved; // [R07]
      end
   end

   // sys_clk stands for the platform rate, since no PLL lives in logic; the ratio is
   // reported for the real multiplier, and the enable runs only with a legal code
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         platform_bus_clock_ff <= 1'b0;
      end else begin
         platform_bus_clock_ff <= config_valid_ff; // [R01]
      end
   end

   // divide-by-two phase for the memory clock
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         half_ff <= 1'b0;
      end else if (config_valid_ff) begin
         half_ff <= ~half_ff; // [R06]
      end
   end

   // memory clock enable on every second platform enable
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         memory_bus_clock_ff <= 1'b0;
      end else begin
         memory_bus_clock_ff <= config_valid_ff & half_ff; // [R06]
      end
   end
endmodule : pcr_clock_ratio

// *** pcr_params.svh ***
// constants for the platform clock ratio strap block
// Overview of operation
// [R01] platform bus clock equals reference clock times ratio from strap captured at power-up; here sys_clk stands for it and the ratio is only reported
// [R02] codes 0,2,3,4,5,6,8,9,10,12,13 map to 16,2,3,4,5,6,8,9,10,12,20; rest reserved
// [R03] no default multiplier; ratio comes only from the sampled strap value
// [R04] board holds every strap bit at its intended level through power-up
// [R05] board picks a ratio making platform clock equal the memory data rate
// [R06] memory bus clock runs at half the platform bus clock
// [R07] reserved strap code raises an invalid configuration flag, no multiplier chosen
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH
`define PCR_STRAP_W      4
`define PCR_RATIO_W      5
`define PCR_SETTLE_CYC   4
`define PCR_SETTLE_W     8
`define PCR_SETTLE_MIN   2
`define PCR_SETTLE_MAX   255
`define PCR_SETTLE_ZERO  8'h00
`define PCR_SETTLE_ONE   8'h01
`define PCR_SYNC_LAST    8'h01
`define PCR_STRAP_RST    4'h0
`define PCR_RATIO_NONE   5'h00
`define PCR_CODE_R16     4'h0
`define PCR_CODE_R2      4'h2
`define PCR_CODE_R3      4'h3
`define PCR_CODE_R4      4'h4
`define PCR_CODE_R5      4'h5
`define PCR_CODE_R6      4'h6
`define PCR_CODE_R8      4'h8
`define PCR_CODE_R9      4'h9
`define PCR_CODE_R10     4'hA
`define PCR_CODE_R12     4'hC
`define PCR_CODE_R20     4'hD
`define PCR_VAL_R16      5'h10
`define PCR_VAL_R2       5'h02
`define PCR_VAL_R3       5'h03
`define PCR_VAL_R4       5'h04
`define PCR_VAL_R5       5'h05
`define PCR_VAL_R6       5'h06
`define PCR_VAL_R8       5'h08
`define PCR_VAL_R9       5'h09
`define PCR_VAL_R10      5'h0A
`define PCR_VAL_R12      5'h0C
`define PCR_VAL_R20      5'h14
`endif

// *** pcr_pkg.sv ***
// types for the platform clock ratio strap block
package pcr_pkg;
   typedef enum logic [1:0] {
      PCR_SYNC   = 2'b00,
      PCR_SETTLE = 2'b01,
      PCR_LOCKED = 2'b10
   } pcr_state_t;
endpackage : pcr_pkg

// *** pcr_strap_board.sv ***
// board strap resistors holding the ratio code
`timescale 1ns/1ns
module pcr_strap_board (
   // code chosen for the board
   input wire logic [3:0] code,
   // strap pins to the block
   output logic     [3:0] clock_ratio_strap
);
   assign clock_ratio_strap = code; // held steady through power-up
endmodule : pcr_strap_board

// *** pcr_clock_ratio_props.sv ***
// port assertions for the clock ratio block
`timescale 1ns/1ns
`include "pcr_params.svh"
module pcr_clock_ratio_props #(parameter int SETTLE_CYC = `PCR_SETTLE_CYC) (
   // clock, reset, strap
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [3:0] clock_ratio_strap,
   // decoded outputs
   input wire logic [3:0] strap_code_ff,
   input wire logic [4:0] ratio_ff,
   input wire logic       config_valid_ff,
   input wire logic       config_invalid_ff,
   input wire logic       platform_bus_clock_ff,
   input wire logic       memory_bus_clock_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence mem_pair;
      memory_bus_clock_ff ##1 !memory_bus_clock_ff ##1 memory_bus_clock_ff;
   endsequence
   one_flag_a: assert property (!(config_valid_ff && config_invalid_ff))
      else $error("valid and invalid both high");
   bad_code_a: assert property (config_invalid_ff |-> ratio_ff == 0 && !platform_bus_clock_ff)
      else $error("reserved code gave a clock");
   lock_hold_a: assert property (config_valid_ff |=> config_valid_ff && $stable(ratio_ff))
      else $error("locked ratio moved");
   no_default_a: assert property (config_valid_ff |-> ratio_ff != 0)
      else $error("valid without ratio");
   code_20_a: assert property (config_valid_ff && strap_code_ff == 4'hD |-> ratio_ff == 5'h14)
      else $error("code D not 20");
   plat_run_a: assert property (config_valid_ff |=> platform_bus_clock_ff)
      else $error("platform enable missing");
   mem_half_a: assert property (memory_bus_clock_ff |-> mem_pair)
      else $error("memory enable not half rate");
endmodule : pcr_clock_ratio_props

// *** test_platform_clock_ratio_strap.sv ***
// self-checking bench for the clock ratio block
`timescale 1ns/1ns
module test_platform_clock_ratio_strap;
   logic       sys_clk, rst_n, config_valid_ff, config_invalid_ff, platform_bus_clock_ff, memory_bus_clock_ff;
   logic [3:0] code, clock_ratio_strap, strap_code_ff;
   logic [4:0] ratio_ff;
   logic [7:0] p, m;
   int         bad_count, checks, n;
   // expected ratio per code, zero marks a reserved code
   logic [4:0] rows [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
      5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h00};
   pcr_strap_board i_pcr_strap_board (.code, .clock_ratio_strap);
   pcr_clock_ratio #(.SETTLE_CYC(2)) i_pcr_clock_ratio (.sys_clk, .rst_n, .clock_ratio_strap, .strap_code_ff,
      .ratio_ff, .config_valid_ff, .config_invalid_ff, .platform_bus_clock_ff, .memory_bus_clock_ff);
   task chk(input logic [7:0] s, input logic [7:0] e, input string w);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", w, e, s);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // reset held 8 cycles, then a bounded wait for the lock
   task boot(input logic [3:0] c);
      rst_n = 0;
      code = c;
      repeat (8) @(negedge sys_clk);
      rst_n = 1;
      for (n = 0; n < 40 && (config_valid_ff | config_invalid_ff) !== 1'b1; n++) @(negedge sys_clk);
      if (n == 40) begin
         bad_count++;
         end_sim;
      end
   endtask : boot
   initial begin
      sys_clk = 0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      {bad_count, checks, rst_n, code} = 0;
      @(negedge sys_clk);
      for (int i = 0; i < 16; i++) begin
         boot(i[3:0]);
         chk(ratio_ff, rows[i], "ratio");
         chk(config_valid_ff, rows[i] != 0, "valid");
         chk(config_invalid_ff, rows[i] == 0, "invalid");
         chk(strap_code_ff, i[3:0], "code");
         @(negedge sys_clk);
         chk(platform_bus_clock_ff, rows[i] != 0, "platform run");
         $display("code %0d done", i);
      end
      // strap moves after lock: must be ignored, enables keep their rates
      boot(4'hD);
      code = 4'h3;
      {p, m} = 0;
      repeat (8) begin
         @(negedge sys_clk);
         p += platform_bus_clock_ff;
         m += memory_bus_clock_ff;
      end
      chk(ratio_ff, 5'h14, "held ratio");
      chk(p, 8'h08, "platform");
      chk(m, 8'h04, "memory");
      // a strap that never settles gets no default ratio
      rst_n = 0;
      repeat (8) @(negedge sys_clk);
      chk(ratio_ff, 8'h00, "reset ratio");
      chk({config_valid_ff, config_invalid_ff, platform_bus_clock_ff, memory_bus_clock_ff}, 8'h00, "reset flags");
      rst_n = 1;
      repeat (20) begin
         @(negedge sys_clk);
         code = ~code;
      end
      chk(config_valid_ff | config_invalid_ff, 8'h00, "no lock");
      $display("awkward cases done");
      end_sim;
   end
endmodule : test_platform_clock_ratio_strap
bind pcr_clock_ratio pcr_clock_ratio_props #(.SETTLE_CYC(SETTLE_CYC)) i_props (.sys_clk, .rst_n, .clock_ratio_strap,
   .strap_code_ff, .ratio_ff, .config_valid_ff, .config_invalid_ff, .platform_bus_clock_ff, .memory_bus_clock_ff);
